// *** saga_pkg.sv ***
package saga_pkg;

   localparam int          ADDR_W       = 16;
   localparam int          FADDR_W      = 13;
   localparam int          PC_HI_W      = 7;
   localparam int          LIT5_W       = 5;
   localparam logic [15:0] WORD_BYTES   = 16'h0002;
   localparam logic [15:0] SFR_END      = 16'h0800;
   localparam logic [15:0] SP_RESET     = 16'h0800;
   localparam logic [3:0]  SP_IDX       = 4'hF;
   localparam logic [3:0]  DEFAULT_WORKING_REGISTER_IDX     = 4'h0;
   localparam logic [15:0] LIM_ALIGN    = 16'hFFFE;
   localparam logic [7:0]  ZERO_BYTE    = 8'h00;
   localparam logic [15:0] ZERO_WORD    = 16'h0000;

   typedef enum logic [6:0] {
      SAGA_FDIR = 7'h01,
      SAGA_RDIR = 7'h02,
      SAGA_IND  = 7'h04,
      SAGA_POST = 7'h08,
      SAGA_PRE  = 7'h10,
      SAGA_ROFF = 7'h20,
      SAGA_LOFF = 7'h40
   } saga_mode_e;

   typedef enum logic [4:0] {
      SAGA_STK_NONE = 5'h01,
      SAGA_STK_PUSH = 5'h02,
      SAGA_STK_POP  = 5'h04,
      SAGA_STK_CALL = 5'h08,
      SAGA_STK_EXC  = 5'h10
   } saga_stk_e;

   typedef enum logic [1:0] {
      SAGA_ST_IDLE = 2'h1,
      SAGA_ST_PCHI = 2'h2
   } saga_state_e;

   typedef struct packed {
      logic                valid;
      saga_mode_e          mode;
      saga_stk_e           stk;
      logic                write;
      logic [3:0]          ptr;
      logic [3:0]          base;
      logic [FADDR_W-1:0]  faddr;
      logic [15:0]         offset;
      logic [15:0]         wdata;
      logic                to_default_working_register;
      logic                op2_lit;
      logic [LIT5_W-1:0]   lit5;
   } saga_req_s;

   typedef struct packed {
      logic                en;
      logic [15:0]         lo;
      logic [15:0]         hi;
      logic                from_owner;
   } saga_seg_s;

   typedef struct packed {
      logic                valid;
      logic [3:0]          idx;
      logic [15:0]         data;
   } saga_wb_s;

   typedef struct packed {
      logic                to_default_working_register;
      logic [3:0]          dest_idx;
      logic [3:0]          op1_idx;
      logic                op2_lit;
      logic [15:0]         lit;
   } saga_op_s;

endpackage

// *** saga_core.sv ***
// Functional notes
// - Stack pointer marks next free word, grows upward.
// - Pop pre-decrements; push uses pointer then increments.
// - Call push zero-extends the counter's top byte.
// - Exception push joins status low byte to top.
// - Stack limit register has no reset value.
// - Stack limit bit zero always reads zero.
// - Stack-pointer addresses are checked against the limit.
// - Push at limit passes; the next push traps.
// - Stack address below 0x0800 raises stack trap.
// - Boot secure RAM only reachable from boot code.
// - Secure RAM only reachable from secure code.
// - File direct uses 13-bit near address field.
// - File ops default to working register zero.
// - First operand direct; second register, memory, literal.
// - File direct address comes from instruction field.
// - Register indirect uses pointer contents unchanged.
// - Post-modify uses pointer, then writes modified pointer.
// - Pre-modify adds signed constant before forming address.
// - Indexed address is pointer plus base register.
// - Literal offset address is pointer plus literal.
`timescale 1ns/1ps
module saga_core (
   input  wire logic                       ref_clk_i,
   input  wire logic                       rst_i,
   input  wire saga_pkg::saga_req_s        req_i,
   input  wire logic [15:0]                ptr_val_i,
   input  wire logic [15:0]                base_val_i,
   input  wire logic [22:0]                pc_i,
   input  wire logic [7:0]                 status_low_byte_i,
   input  wire logic                       sp_wr_i,
   input  wire logic [15:0]                sp_data_i,
   input  wire logic                       lim_wr_i,
   input  wire logic [15:0]                lim_data_i,
   input  wire saga_pkg::saga_seg_s        boot_seg_i,
   input  wire saga_pkg::saga_seg_s        secure_seg_i,
   output logic                            busy_o,
   output logic [15:0]                     ea_o,
   output logic                            mem_rd_o,
   output logic                            mem_wr_o,
   output logic [15:0]                     mem_wdata_o,
   output saga_pkg::saga_wb_s              wb_o,
   output saga_pkg::saga_op_s              op_o,
   output logic                            trap_o,
   output logic                            reject_o,
   output logic [15:0]                     sp_o
);

   function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
      add16 = 16'(a + b);
   endfunction

   function automatic logic in_seg(input logic [15:0] a, input saga_pkg::saga_seg_s s);
      in_seg = s.en && (a >= s.lo) && (a <= s.hi);
   endfunction

   saga_pkg::saga_state_e state;
   saga_pkg::saga_state_e next_state;
   logic [15:0]           stack_pointer_register;
   logic [15:0]           stack_limit_register;
   logic [15:0]           pchi_word;
   logic [15:0]           next_pchi_word;

   logic                  accept;
   logic [15:0]           p;
   logic [15:0]           b;
   logic [15:0]           ea;
   logic                  access;
   logic                  is_wr;
   logic [15:0]           wdata;
   logic                  uses_sp;
   logic                  next_trap;
   logic                  next_reject;
   logic                  do_access;
   logic                  sp_upd;
   logic [15:0]           next_sp;
   logic                  ptr_upd;
   logic [15:0]           ptr_new;

   assign accept = req_i.valid && (state == saga_pkg::SAGA_ST_IDLE);

   always_comb begin
      p = (req_i.ptr == saga_pkg::SP_IDX) ? stack_pointer_register : ptr_val_i;
      b = (req_i.base == saga_pkg::SP_IDX) ? stack_pointer_register : base_val_i;
      ea = saga_pkg::ZERO_WORD;
      access = 1'b0;
      is_wr = req_i.write;
      wdata = req_i.wdata;
      uses_sp = 1'b0;
      sp_upd = 1'b0;
      next_sp = stack_pointer_register;
      ptr_upd = 1'b0;
      ptr_new = p;
      next_state = state;
      next_pchi_word = pchi_word;
      if (state == saga_pkg::SAGA_ST_PCHI) begin
         ea = stack_pointer_register;
         access = 1'b1;
         is_wr = 1'b1;
         wdata = pchi_word;
         uses_sp = 1'b1;
         sp_upd = 1'b1;
         next_sp = add16(stack_pointer_register, saga_pkg::WORD_BYTES);
         next_state = saga_pkg::SAGA_ST_IDLE;
      end else if (req_i.valid) begin
         unique case (req_i.stk)
            saga_pkg::SAGA_STK_PUSH, saga_pkg::SAGA_STK_CALL, saga_pkg::SAGA_STK_EXC: begin
               ea = stack_pointer_register;
               access = 1'b1;
               is_wr = 1'b1;
               uses_sp = 1'b1;
               sp_upd = 1'b1;
               next_sp = add16(stack_pointer_register, saga_pkg::WORD_BYTES);
               if (req_i.stk != saga_pkg::SAGA_STK_PUSH) begin
                  wdata = pc_i[15:0];
                  next_state = saga_pkg::SAGA_ST_PCHI;
               end
               if (req_i.stk == saga_pkg::SAGA_STK_CALL) begin
                  next_pchi_word = {saga_pkg::ZERO_BYTE, 1'b0, pc_i[22:16]};
               end else begin
                  next_pchi_word = {status_low_byte_i, 1'b0, pc_i[22:16]};
               end
            end
            saga_pkg::SAGA_STK_POP: begin
               ea = add16(stack_pointer_register, -saga_pkg::WORD_BYTES);
               access = 1'b1;
               is_wr = 1'b0;
               uses_sp = 1'b1;
               sp_upd = 1'b1;
               next_sp = ea;
            end
            saga_pkg::SAGA_STK_NONE: begin
               uses_sp = (req_i.ptr == saga_pkg::SP_IDX) &&
                         (req_i.mode != saga_pkg::SAGA_FDIR) &&
                         (req_i.mode != saga_pkg::SAGA_RDIR);
               access = (req_i.mode != saga_pkg::SAGA_RDIR);
               unique case (req_i.mode)
                  saga_pkg::SAGA_FDIR: ea = {3'h0, req_i.faddr};
                  saga_pkg::SAGA_RDIR: ea = saga_pkg::ZERO_WORD;
                  saga_pkg::SAGA_IND:  ea = p;
                  saga_pkg::SAGA_POST: begin
                     ea = p;
                     ptr_upd = 1'b1;
                     ptr_new = add16(p, req_i.offset);
                  end
                  saga_pkg::SAGA_PRE: begin
                     ea = add16(p, req_i.offset);
                     ptr_upd = 1'b1;
                     ptr_new = ea;
                  end
                  saga_pkg::SAGA_ROFF: ea = add16(p, b);
                  saga_pkg::SAGA_LOFF: ea = add16(p, req_i.offset);
                  default:             ea = saga_pkg::ZERO_WORD;
               endcase
            end
            default: access = 1'b0;
         endcase
      end
      // A push that lands on the limit passes; one beyond it traps.
      next_trap = access && uses_sp &&
                  ((ea > stack_limit_register) || (ea < saga_pkg::SFR_END));
      next_reject = access && !next_trap &&
                    ((in_seg(ea, boot_seg_i) && !boot_seg_i.from_owner) ||
                     (in_seg(ea, secure_seg_i) && !secure_seg_i.from_owner));
      do_access = access && !next_trap && !next_reject;
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= saga_pkg::SAGA_ST_IDLE;
         pchi_word <= saga_pkg::ZERO_WORD;
      end else begin
         state <= (next_trap || next_reject) ? saga_pkg::SAGA_ST_IDLE : next_state;
         pchi_word <= next_pchi_word;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         stack_pointer_register <= saga_pkg::SP_RESET;
      end else if (do_access && sp_upd) begin
         stack_pointer_register <= next_sp;
      end else if (do_access && ptr_upd && req_i.ptr == saga_pkg::SP_IDX) begin
         stack_pointer_register <= ptr_new & saga_pkg::LIM_ALIGN;
      end else if (sp_wr_i) begin
         stack_pointer_register <= sp_data_i & saga_pkg::LIM_ALIGN;
      end
   end

   // The limit has no reset on purpose; software must load it before use.
   always_ff @(posedge ref_clk_i) begin
      if (lim_wr_i) begin
         stack_limit_register <= lim_data_i & saga_pkg::LIM_ALIGN;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ea_o <= saga_pkg::ZERO_WORD;
         mem_rd_o <= 1'b0;
         mem_wr_o <= 1'b0;
         mem_wdata_o <= saga_pkg::ZERO_WORD;
         trap_o <= 1'b0;
         reject_o <= 1'b0;
      end else begin
         ea_o <= ea;
         mem_rd_o <= do_access && !is_wr;
         mem_wr_o <= do_access && is_wr;
         mem_wdata_o <= wdata;
         trap_o <= next_trap;
         reject_o <= next_reject;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wb_o <= '0;
      end else begin
         wb_o.valid <= do_access && ptr_upd && (req_i.ptr != saga_pkg::SP_IDX);
         wb_o.idx <= req_i.ptr;
         wb_o.data <= ptr_new;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         op_o <= '0;
      end else if (accept) begin
         op_o.to_default_working_register <= req_i.to_default_working_register;
         op_o.dest_idx <= saga_pkg::DEFAULT_WORKING_REGISTER_IDX;
         op_o.op1_idx <= req_i.base;
         op_o.op2_lit <= req_i.op2_lit;
         op_o.lit <= {11'h000, req_i.lit5};
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         busy_o <= 1'b0;
         sp_o <= saga_pkg::SP_RESET;
      end else begin
         busy_o <= (next_state == saga_pkg::SAGA_ST_PCHI) && !next_trap && !next_reject;
         sp_o <= (do_access && sp_upd) ? next_sp : stack_pointer_register;
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   chk_push_increments: assert property (
      accept && req_i.stk == saga_pkg::SAGA_STK_PUSH && do_access
      |=> stack_pointer_register == add16($past(stack_pointer_register), saga_pkg::WORD_BYTES)
          && ea_o == $past(stack_pointer_register) && mem_wr_o)
      else $error("push did not post-increment the stack pointer");

   chk_pop_decrements: assert property (
      accept && req_i.stk == saga_pkg::SAGA_STK_POP && do_access
      |=> mem_rd_o && ea_o == stack_pointer_register
          && ea_o == add16($past(stack_pointer_register), -saga_pkg::WORD_BYTES))
      else $error("pop did not pre-decrement the stack pointer");

   chk_call_msb_zero: assert property (
      accept && req_i.stk == saga_pkg::SAGA_STK_CALL && do_access
      ##1 (state == saga_pkg::SAGA_ST_PCHI && do_access)
      |=> mem_wr_o && mem_wdata_o[15:7] == 9'h000)
      else $error("call push high word not zero extended");

   chk_exc_status_byte: assert property (
      accept && req_i.stk == saga_pkg::SAGA_STK_EXC && do_access
      ##1 (state == saga_pkg::SAGA_ST_PCHI && do_access)
      |=> mem_wdata_o[15:8] == $past(status_low_byte_i, 2))
      else $error("exception push lacks status low byte");

   chk_limit_aligned: assert property (
      lim_wr_i |=> !stack_limit_register[0] && stack_limit_register[15:1] == $past(lim_data_i[15:1]))
      else $error("stack limit bit zero not held low");

   chk_limit_trap: assert property (
      accept && req_i.stk == saga_pkg::SAGA_STK_PUSH && stack_pointer_register > stack_limit_register
      |=> trap_o && !mem_wr_o && $stable(stack_pointer_register))
      else $error("push beyond limit did not trap");

   chk_underflow_trap: assert property (
      accept && uses_sp && access && ea < saga_pkg::SFR_END
      |=> trap_o && !mem_rd_o && !mem_wr_o)
      else $error("stack address below special space did not trap");

   chk_secure_reject: assert property (
      reject_o |-> !mem_rd_o && !mem_wr_o && !trap_o)
      else $error("rejected secure access reached memory");

   chk_file_direct: assert property (
      accept && req_i.stk == saga_pkg::SAGA_STK_NONE && req_i.mode == saga_pkg::SAGA_FDIR
      |=> ea_o[15:13] == 3'h0 && ea_o[12:0] == $past(req_i.faddr))
      else $error("file direct address wrong");

   chk_post_modify: assert property (
      accept && req_i.stk == saga_pkg::SAGA_STK_NONE && req_i.mode == saga_pkg::SAGA_POST
      && req_i.ptr != saga_pkg::SP_IDX && do_access
      |=> ea_o == $past(ptr_val_i) && wb_o.valid && wb_o.data == add16(ea_o, $past(req_i.offset)))
      else $error("post-modify address or writeback wrong");

   chk_indexed: assert property (
      accept && req_i.stk == saga_pkg::SAGA_STK_NONE && req_i.mode == saga_pkg::SAGA_ROFF
      && req_i.ptr != saga_pkg::SP_IDX && req_i.base != saga_pkg::SP_IDX
      |=> ea_o == add16($past(ptr_val_i), $past(base_val_i)) && !wb_o.valid)
      else $error("indexed address wrong");

   chk_trap_pulse: assert property (
      trap_o && $past(state) == saga_pkg::SAGA_ST_PCHI |-> state == saga_pkg::SAGA_ST_IDLE)
      else $error("trap left a pending high word push");

   chk_push_at_limit: assert property (
      accept && req_i.stk == saga_pkg::SAGA_STK_PUSH
      && stack_pointer_register == stack_limit_register
      && stack_pointer_register >= saga_pkg::SFR_END
      |=> !trap_o)
      else $error("push at the limit trapped");

   chk_indirect: assert property (
      accept && req_i.stk == saga_pkg::SAGA_STK_NONE && req_i.mode == saga_pkg::SAGA_IND
      && req_i.ptr != saga_pkg::SP_IDX
      |=> ea_o == $past(ptr_val_i) && !wb_o.valid)
      else $error("register indirect address wrong");

   chk_pre_modify: assert property (
      accept && req_i.stk == saga_pkg::SAGA_STK_NONE && req_i.mode == saga_pkg::SAGA_PRE
      && req_i.ptr != saga_pkg::SP_IDX && do_access
      |=> ea_o == add16($past(ptr_val_i), $past(req_i.offset))
          && wb_o.valid && wb_o.data == ea_o)
      else $error("pre-modify address or writeback wrong");

   chk_lit_offset: assert property (
      accept && req_i.stk == saga_pkg::SAGA_STK_NONE && req_i.mode == saga_pkg::SAGA_LOFF
      && req_i.ptr != saga_pkg::SP_IDX
      |=> ea_o == add16($past(ptr_val_i), $past(req_i.offset)) && !wb_o.valid)
      else $error("literal offset address wrong");

   chk_working_reg: assert property (
      accept |=> op_o.dest_idx == saga_pkg::DEFAULT_WORKING_REGISTER_IDX && op_o.op1_idx == $past(req_i.base)
          && op_o.to_default_working_register == $past(req_i.to_default_working_register) && op_o.op2_lit == $past(req_i.op2_lit)
          && op_o.lit == {11'h000, $past(req_i.lit5)})
      else $error("working register operand selection wrong");

   chk_secure_block: assert property (
      accept && access && !next_trap
      && ((in_seg(ea, boot_seg_i) && !boot_seg_i.from_owner)
          || (in_seg(ea, secure_seg_i) && !secure_seg_i.from_owner))
      |=> reject_o && !mem_rd_o && !mem_wr_o)
      else $error("foreign access to secure RAM not rejected");

   chk_trap_blocks: assert property (
      trap_o |-> !mem_rd_o && !mem_wr_o && !wb_o.valid && !reject_o)
      else $error("trapped access still reached memory");

endmodule

// *** saga_exec_model.sv ***
`timescale 1ns/1ps
// Register file of the execute stage: supplies pointer and base contents
// and takes back the modified pointers that the block hands over.
module saga_exec_model (
   input  wire logic               ref_clk_i,
   input  wire logic               rst_i,
   input  wire logic [3:0]         ptr_idx_i,
   input  wire logic [3:0]         base_idx_i,
   input  wire saga_pkg::saga_wb_s wb_i,
   output logic [15:0]             ptr_val_o,
   output logic [15:0]             base_val_o
);
   logic [15:0] regs [16];

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < 16; i++) begin
            regs[i] <= {4'h1, 4'(i), 8'h20};
         end
      end else if (wb_i.valid) begin
         regs[wb_i.idx] <= wb_i.data;
      end
   end

   assign ptr_val_o  = regs[ptr_idx_i];
   assign base_val_o = regs[base_idx_i];
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
   localparam saga_pkg::saga_stk_e  NONE = saga_pkg::SAGA_STK_NONE;
   localparam saga_pkg::saga_stk_e  PUSH = saga_pkg::SAGA_STK_PUSH;
   localparam saga_pkg::saga_stk_e  POP  = saga_pkg::SAGA_STK_POP;
   localparam saga_pkg::saga_mode_e IND  = saga_pkg::SAGA_IND;
   localparam saga_pkg::saga_mode_e LOFF = saga_pkg::SAGA_LOFF;
   localparam saga_pkg::saga_mode_e FDIR = saga_pkg::SAGA_FDIR;
   logic                ref_clk_i = 1'b0;
   logic                rst_i     = 1'b1;
   saga_pkg::saga_req_s req       = '0;
   logic [15:0]         ptr_val, base_val, ea, wdata, sp;
   logic [15:0]         lim_d = '0;
   logic [15:0]         sp_d  = '0;
   logic [22:0]         pc      = 23'h5ABCDE;
   logic [7:0]          stat_lo = 8'hC3;
   logic                sp_wr  = 1'b0;
   logic                lim_wr = 1'b0;
   logic                busy, rd, wr, trap, rej;
   saga_pkg::saga_seg_s bseg = '{1'b1, 16'h1000, 16'h10FF, 1'b0};
   saga_pkg::saga_seg_s sseg = '{1'b1, 16'h1100, 16'h11FF, 1'b0};
   saga_pkg::saga_wb_s  wb;
   saga_pkg::saga_op_s  op;
   int                  error_cnt = 0;
   int                  n_checks  = 0;
   int                  cyc       = 0;
   wire [4:0]           fl = {busy, rd, wr, trap, rej};

   always #20 ref_clk_i = ~ref_clk_i;

   saga_core dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req), .ptr_val_i(ptr_val),
      .base_val_i(base_val), .pc_i(pc), .status_low_byte_i(stat_lo), .sp_wr_i(sp_wr),
      .sp_data_i(sp_d), .lim_wr_i(lim_wr), .lim_data_i(lim_d), .boot_seg_i(bseg),
      .secure_seg_i(sseg), .busy_o(busy), .ea_o(ea), .mem_rd_o(rd), .mem_wr_o(wr),
      .mem_wdata_o(wdata), .wb_o(wb), .op_o(op), .trap_o(trap), .reject_o(rej), .sp_o(sp));

   saga_exec_model model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ptr_idx_i(req.ptr),
      .base_idx_i(req.base), .wb_i(wb), .ptr_val_o(ptr_val), .base_val_o(base_val));

   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         error_cnt++;
         complete_run();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Presents one request; the answer stands when the task returns.
   task automatic go(input saga_pkg::saga_mode_e m, input saga_pkg::saga_stk_e s,
                     input logic [3:0] p, input logic [15:0] off);
      req = '{1'b1, m, s, 1'b0, p, 4'h2, off[12:0], off, 16'hA5C3, 1'b1, 1'b1, 5'h15};
      @(negedge ref_clk_i);
   endtask

   task automatic idle();
      req.valid = 1'b0;
      @(negedge ref_clk_i);
   endtask

   // Writes the limit or the stack pointer, then leaves a quiet cycle.
   task automatic load(input logic to_lim, input logic [15:0] v);
      {lim_d, sp_d} = {v, v};
      {lim_wr, sp_wr} = {to_lim, !to_lim};
      @(negedge ref_clk_i);
      {lim_wr, sp_wr} = 2'b00;
      @(negedge ref_clk_i);
   endtask

   task automatic t_limit();
      load(1'b1, 16'h0805);
      go(LOFF, NONE, 4'hF, 16'h0005);
      chk(16'(fl), 16'h0002);
      go(LOFF, NONE, 4'hF, 16'h0004);
      chk(16'(fl), 16'h0008);
      chk(ea, 16'h0804);
      idle();
   endtask

   task automatic t_push();
      for (int i = 0; i < 3; i++) begin
         go(IND, PUSH, 4'hF, 16'h0000);
         chk(16'(fl), 16'h0004);
         chk(ea, 16'h0800 + 16'(2 * i));
         chk(sp, 16'h0802 + 16'(2 * i));
         chk(wdata, 16'hA5C3);
      end
      go(IND, PUSH, 4'hF, 16'h0000);
      chk(16'(fl), 16'h0002);
      chk(sp, 16'h0806);
      idle();
   endtask

   task automatic t_pop();
      go(IND, POP, 4'hF, 16'h0000);
      chk(16'(fl), 16'h0008);
      chk(ea, 16'h0804);
      chk(sp, 16'h0804);
      idle();
      load(1'b0, 16'h0800);
      go(IND, POP, 4'hF, 16'h0000);
      chk(16'(fl), 16'h0002);
      chk(sp, 16'h0800);
      idle();
   endtask

   task automatic t_call();
      load(1'b1, 16'h0FFE);
      go(IND, saga_pkg::SAGA_STK_CALL, 4'hF, 16'h0000);
      chk(16'(fl), 16'h0014);
      chk(wdata, 16'hBCDE);
      idle();
      chk(ea, 16'h0802);
      chk(wdata, 16'h005A);
      go(IND, saga_pkg::SAGA_STK_EXC, 4'hF, 16'h0000);
      chk(ea, 16'h0804);
      idle();
      chk(wdata, 16'hC35A);
      chk(sp, 16'h0808);
      load(1'b1, 16'h0808);
      go(IND, saga_pkg::SAGA_STK_CALL, 4'hF, 16'h0000);
      chk(16'(fl), 16'h0014);
      idle();
      chk(16'(fl), 16'h0002);
      chk(sp, 16'h080A);
      idle();
   endtask

   task automatic t_modes();
      go(FDIR, NONE, 4'h0, 16'h1FFF);
      chk(ea, 16'h1FFF);
      chk({op.dest_idx, op.op1_idx}, 16'h0002);
      chk(op.lit, 16'h0015);
      go(saga_pkg::SAGA_RDIR, NONE, 4'h3, 16'h0000);
      chk(16'(fl), 16'h0000);
      go(IND, NONE, 4'h3, 16'h0000);
      chk(ea, 16'h1320);
      go(saga_pkg::SAGA_POST, NONE, 4'h3, 16'h0002);
      chk(ea, 16'h1320);
      chk({wb.valid, wb.idx, wb.data[10:0]}, {1'b1, 4'h3, 11'h322});
      idle();
      go(IND, NONE, 4'h3, 16'h0000);
      chk(ea, 16'h1322);
      go(saga_pkg::SAGA_PRE, NONE, 4'h4, 16'hFFFE);
      chk(ea, 16'h141E);
      chk(wb.data, 16'h141E);
      go(saga_pkg::SAGA_ROFF, NONE, 4'h5, 16'h0000);
      chk(ea, 16'h2740);
      go(LOFF, NONE, 4'h6, 16'h0010);
      chk(ea, 16'h1630);
      idle();
   endtask

   task automatic t_secure();
      for (int k = 0; k < 4; k++) begin
         bseg.from_owner = k[0];
         sseg.from_owner = k[0];
         go(FDIR, NONE, 4'h0, k[1] ? 16'h11F0 : 16'h1000);
         chk(16'(fl), k[0] ? 16'h0008 : 16'h0001);
      end
      idle();
   endtask

   initial begin
      repeat (20) @(negedge ref_clk_i);
      rst_i = 1'b0;
      @(negedge ref_clk_i);
      chk(sp, 16'h0800);
      chk(16'(fl), 16'h0000);
      t_limit();
      t_push();
      t_pop();
      t_call();
      t_modes();
      t_secure();
      complete_run();
   end
endmodule
